// ### verilog/qtm_pkg.sv
package qtm_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] QTM_RAM_BASE = 12'h050;
  localparam logic [11:0] QTM_RAM_LAST = 12'h14c;
  localparam logic [11:0] QTM_TABLE_STRIDE = 12'h040;
  localparam logic [11:0] QTM_CTRL0_OFFS = 12'h000;
  localparam logic [11:0] QTM_STATUS_OFFS = 12'h004;
  localparam logic [11:0] QTM_ZZ_OFFS = 12'h008;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int QTM_START_BIT = 0;
  localparam int QTM_NUM_TABLES = 4;
  localparam int QTM_WORDS_PER_TABLE = 16;
  localparam int QTM_NUM_WORDS = 64;
  localparam int QTM_COEF_BITS = 8;
  localparam logic [31:0] QTM_CTRL0_RESET = 32'h0000_0000;
  localparam logic [1:0] QTM_RESP_OKAY = 2'h0;
  localparam logic [1:0] QTM_RESP_SLVERR = 2'h2;

  // Core-side coefficient lookup
  typedef struct packed {
    logic [1:0] table_sel;
    logic [2:0] row;
    logic [2:0] col;
  } qtm_coef_req_t;

  typedef enum logic [1:0] {
    QTM_IDLE,
    QTM_WAIT_B,
    QTM_WAIT_R
  } qtm_bus_state_t;

endpackage : qtm_pkg

// ### verilog/qtm_zigzag.sv
// ----------------------------------------
// Raster (row, col) to zig-zag index
// ----------------------------------------
module qtm_zigzag (
  input wire logic [2:0] row,
  input wire logic [2:0] col,
  output logic [5:0] zz_index
);

  // Index table walked in raster order, row 0 first
  localparam logic [383:0] ZZ_TABLE = {
    6'h3f, 6'h3e, 6'h3a, 6'h39, 6'h31, 6'h30, 6'h24, 6'h23,
    6'h3d, 6'h3b, 6'h38, 6'h32, 6'h2f, 6'h25, 6'h22, 6'h15,
    6'h3c, 6'h37, 6'h33, 6'h2e, 6'h26, 6'h21, 6'h16, 6'h14,
    6'h36, 6'h34, 6'h2d, 6'h27, 6'h20, 6'h17, 6'h13, 6'h0a,
    6'h35, 6'h2c, 6'h28, 6'h1f, 6'h18, 6'h12, 6'h0b, 6'h09,
    6'h2b, 6'h29, 6'h1e, 6'h19, 6'h11, 6'h0c, 6'h08, 6'h03,
    6'h2a, 6'h1d, 6'h1a, 6'h10, 6'h0d, 6'h07, 6'h04, 6'h02,
    6'h1c, 6'h1b, 6'h0f, 6'h0e, 6'h06, 6'h05, 6'h01, 6'h00
  };

  // Table lookup, six bits per entry; nine-bit offset reaches 378
  always_comb begin
    zz_index = ZZ_TABLE[{1'b0, row, col, 2'b00} + {2'b00, row, col, 1'b0} +: 6];
  end

endmodule : qtm_zigzag

// ### verilog/qtm_table_ram.sv
// Notes on behaviour
// - Quantization RAM sits at offsets 0x050 through 0x14c of register space.
// - Each table is 64 bytes, sixteen consecutive 32-bit words.
// - Tables lie back to back on a 64-byte stride from 0x050.
// - Coefficients are kept and fetched in zig-zag order by core and software.
// - Zig-zag index 0 top-left, 1 right, 2 below, ends 63 bottom-right.
// - RAM is reachable by software only while the start bit is clear.
// - Each coefficient is one byte for 8-bit sample data.
module qtm_table_ram
  import qtm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Codec core side
  input wire logic core_done,
  input wire qtm_coef_req_t coef_req,
  output logic [QTM_COEF_BITS-1:0] coef_data,
  output logic codec_start
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] ram_q [QTM_NUM_WORDS];
  logic [31:0] ram_d [QTM_NUM_WORDS];
  logic start_q, start_d;
  logic [QTM_COEF_BITS-1:0] coef_q, coef_d;
  logic [5:0] zz_q, zz_d;
  qtm_bus_state_t st_q, st_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [5:0] zz_index;
  logic [11:0] wr_rel, rd_rel;
  logic wr_in_ram, rd_in_ram;
  logic [11:0] wr_addr, rd_addr;
  logic aw_hs, w_hs;

  // ----------------------------------------
  // Zig-zag translation for the core
  // ----------------------------------------
  // raster to zig-zag
  qtm_zigzag u_zigzag (
    .row(coef_req.row),
    .col(coef_req.col),
    .zz_index(zz_index)
  );

  assign aw_hs = s_axi_awvalid && awready_q;
  assign w_hs = s_axi_wvalid && wready_q;
  assign wr_addr = aw_hs ? s_axi_awaddr : awaddr_q;
  assign rd_addr = s_axi_araddr;
  assign wr_rel = wr_addr - QTM_RAM_BASE;
  assign rd_rel = rd_addr - QTM_RAM_BASE;
  assign wr_in_ram = (wr_addr >= QTM_RAM_BASE) && (wr_addr <= QTM_RAM_LAST);
  assign rd_in_ram = (rd_addr >= QTM_RAM_BASE) && (rd_addr <= QTM_RAM_LAST);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [31:0] wd;
    logic [3:0] ws;
    logic [5:0] widx;
    wd = w_hs ? s_axi_wdata : wdata_q;
    ws = w_hs ? s_axi_wstrb : wstrb_q;
    widx = 6'h00;
    ram_d = ram_q;
    start_d = start_q;
    st_d = st_q;
    aw_got_d = aw_got_q || aw_hs;
    w_got_d = w_got_q || w_hs;
    awaddr_d = aw_hs ? s_axi_awaddr : awaddr_q;
    wdata_d = wd;
    wstrb_d = ws;
    awready_d = awready_q && !aw_hs;
    wready_d = wready_q && !w_hs;
    arready_d = 1'b0;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    // Core end of operation clears start
    if (core_done) begin
      start_d = 1'b0;
    end
    unique case (st_q)
      QTM_IDLE: begin
        if (aw_got_d && w_got_d) begin
          bresp_d = QTM_RESP_OKAY;
          if (wr_in_ram && !start_q) begin
            widx = wr_rel[7:2];
            for (int b = 0; b < 4; b++) begin
              if (ws[b]) begin
                ram_d[widx][8*b +: 8] = wd[8*b +: 8];
              end
            end
          end else if (wr_addr == QTM_CTRL0_OFFS) begin
            if (ws[0]) begin
              start_d = wd[QTM_START_BIT];
            end
          end else begin
            bresp_d = QTM_RESP_SLVERR;
          end
          bvalid_d = 1'b1;
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
          st_d = QTM_WAIT_B;
        end else if (s_axi_arvalid && !aw_got_q && !w_got_q) begin
          arready_d = 1'b1;
          st_d = QTM_WAIT_R;
        end
      end
      QTM_WAIT_B: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          awready_d = 1'b1;
          wready_d = 1'b1;
          st_d = QTM_IDLE;
        end
      end
      QTM_WAIT_R: begin
        if (arready_q) begin
          rresp_d = QTM_RESP_OKAY;
          rdata_d = 32'h0000_0000;
          if (rd_in_ram && !start_q) begin
            rdata_d = ram_q[rd_rel[7:2]];
          end else if (rd_addr == QTM_CTRL0_OFFS) begin
            rdata_d[QTM_START_BIT] = start_q;
          end else if (rd_addr == QTM_STATUS_OFFS) begin
            rdata_d = {26'h0000000, zz_q};
          end else begin
            rresp_d = QTM_RESP_SLVERR;
          end
          rvalid_d = 1'b1;
        end else if (rvalid_q && s_axi_rready) begin
          rvalid_d = 1'b0;
          st_d = QTM_IDLE;
        end
      end
    endcase
  end

  // Core coefficient fetch, one-cycle latency
  always_comb begin
    coef_d = ram_q[{coef_req.table_sel, zz_index[5:2]}][8*zz_index[1:0] +: 8];
    zz_d = zz_index;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // RAM words carry no reset
  always_ff @(posedge core_clk) begin
    ram_q <= ram_d;
    coef_q <= coef_d;
    zz_q <= zz_d;
  end

  // Control and bus state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_q <= QTM_CTRL0_RESET[QTM_START_BIT];
      st_q <= QTM_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= QTM_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= QTM_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      start_q <= start_d;
      st_q <= st_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign coef_data = coef_q;
  assign codec_start = start_q;

endmodule : qtm_table_ram

// ### verif/qtm_table_ram_monitor.sv
// ----------------------------------------
// Bus and start-bit checker
// ----------------------------------------
module qtm_table_ram_monitor
  import qtm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_done,
  input wire logic codec_start
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Handshake steps
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_b_follows: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open during response");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_follows: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data missing");
  chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read ready held");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  chk_busy_read: assert property (ar_take ##0 (codec_start && s_axi_araddr >= QTM_RAM_BASE
    && s_axi_araddr <= QTM_RAM_LAST) |=> s_axi_rdata == 32'h0)
    else $error("table read while running");
  chk_unmapped_err: assert property (ar_take ##0 (s_axi_araddr > QTM_RAM_LAST)
    |=> s_axi_rresp == QTM_RESP_SLVERR)
    else $error("unmapped read not refused");
  chk_done_clears: assert property (core_done && !s_axi_wvalid |=> !codec_start)
    else $error("start bit not cleared");
endmodule : qtm_table_ram_monitor

bind qtm_table_ram qtm_table_ram_monitor u_mon (.core_clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .core_done, .codec_start);

// ### verif/qtm_table_ram_tb_top.sv
module qtm_table_ram_tb_top
  import qtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [1:0] r;} qtm_row_t;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic core_done, codec_start;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] coef_data;
  qtm_coef_req_t coef_req;
  int n_errors = 0;
  int tests_run = 0;
  int rsp_lag = 0;
  // Zig-zag index at each raster position
  byte zz[64] = '{0,1,5,6,14,15,27,28,2,4,7,13,16,26,29,42,3,8,12,17,25,30,41,43,9,11,18,24,
    31,40,44,53,10,19,23,32,39,45,52,54,20,22,33,38,46,51,55,60,21,34,37,47,50,56,59,61,35,36,
    48,49,57,58,62,63};
  qtm_row_t rows[6] = '{'{12'h050, 32'h0403_0201, QTM_RESP_OKAY},
    '{12'h08c, 32'ha5a5_5a5a, QTM_RESP_OKAY}, '{12'h090, 32'h1122_3344, QTM_RESP_OKAY},
    '{12'h0d0, 32'hffee_ddcc, QTM_RESP_OKAY}, '{12'h14c, 32'h8070_6050, QTM_RESP_OKAY},
    '{12'h150, 32'h1234_5678, QTM_RESP_SLVERR}};

  qtm_table_ram dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .core_done, .coef_req, .coef_data, .codec_start);

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int left;
    left = rsp_lag;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (left == 0);
    forever begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      // Late bready once the response shows
      if (s_axi_bvalid) begin
        left--;
        if (left == 0) s_axi_bready <= 1'b1;
      end
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int left;
    left = rsp_lag;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (left == 0);
    forever begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      // Late rready once the data shows
      if (s_axi_rvalid) begin
        left--;
        if (left == 0) s_axi_rready <= 1'b1;
      end
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    test_done();
  end

  // Main sequence
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {core_done, s_axi_awaddr, s_axi_araddr, s_axi_wdata, coef_req} = '0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    chk("start after reset", 32'h0, {31'h0, codec_start});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rsp);
      chk("write resp", {30'h0, rows[i].r}, {30'h0, rsp});
      rd(rows[i].a, rd_d, rsp);
      chk("read resp", {30'h0, rows[i].r}, {30'h0, rsp});
      chk("read data", rows[i].r == QTM_RESP_OKAY ? rows[i].d : 32'h0, rd_d);
    end
    $display("test rows done");
    for (int w = 0; w < 16; w++)
      wr(12'h090 + 12'(4 * w), {8'(4*w+3), 8'(4*w+2), 8'(4*w+1), 8'(4*w)}, rsp);
    for (int p = 0; p < 64; p++) begin
      @(posedge core_clk);
      coef_req <= {2'h1, 3'(p / 8), 3'(p % 8)};
      @(posedge core_clk);
      #1 chk("coef", 32'(zz[p]), {24'h0, coef_data});
    end
    rd(QTM_STATUS_OFFS, rd_d, rsp);
    chk("status", 32'd63, {26'h0, rd_d[5:0]});
    $display("test zigzag done");
    wr(QTM_CTRL0_OFFS, 32'h1, rsp);
    chk("start set", 32'h1, {31'h0, codec_start});
    wr(12'h050, 32'hdead_beef, rsp);
    chk("busy write resp", {30'h0, QTM_RESP_SLVERR}, {30'h0, rsp});
    rd(12'h050, rd_d, rsp);
    chk("busy read", 32'h0, rd_d);
    chk("busy read resp", {30'h0, QTM_RESP_SLVERR}, {30'h0, rsp});
    @(posedge core_clk);
    core_done <= 1'b1;
    @(posedge core_clk);
    core_done <= 1'b0;
    @(posedge core_clk);
    #1 chk("done clears start", 32'h0, {31'h0, codec_start});
    rd(12'h050, rd_d, rsp);
    chk("table kept", rows[0].d, rd_d);
    $display("test busy done");
    // Slow responses and byte strobes
    s_axi_wstrb <= 4'h5;
    rsp_lag = 2;
    wr(12'h050, 32'haabb_ccdd, rsp);
    s_axi_wstrb <= 4'hf;
    rd(12'h050, rd_d, rsp);
    rsp_lag = 0;
    chk("strobe write", 32'h04bb_02dd, rd_d);
    chk("slow read resp", {30'h0, QTM_RESP_OKAY}, {30'h0, rsp});
    $display("test strobe done");
    // Reset while running
    wr(QTM_CTRL0_OFFS, 32'h1, rsp);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1 chk("reset clears start", 32'h0, {31'h0, codec_start});
    chk("reset awready", 32'h1, {31'h0, s_axi_awready});
    chk("reset bvalid", 32'h0, {31'h0, s_axi_bvalid});
    rd(QTM_CTRL0_OFFS, rd_d, rsp);
    chk("control after reset", 32'h0, rd_d);
    $display("test reset done");
    test_done();
  end
endmodule : qtm_table_ram_tb_top
